// ===== wdg_pkg.sv
// shared constants and types for the watchdog configuration guard
package wdg_pkg;
   // control register field positions
   localparam int unsigned CHANGE_WINDOW_POS   = 4;
   localparam int unsigned WATCHDOG_ON_POS     = 3;
   localparam int unsigned TIMEOUT_SELECT_MSB  = 2;
   localparam int unsigned TIMEOUT_SELECT_W    = 3;
   localparam int unsigned CTRL_W              = 8;
   // change window lasts this many system clocks
   localparam int unsigned WINDOW_CLOCKS       = 4;
   // shortest period is 16K oscillator cycles, log2 of it
   localparam int unsigned BASE_PERIOD_LOG2    = 14;
   localparam int unsigned PERIOD_CNT_W        = 22;
   localparam logic [7:0]  CTRL_RESET          = 8'h00;
   localparam logic [2:0]  TIMEOUT_RESET       = 3'h0;
   // controller register map (word indices on the software port)
   localparam logic [1:0]  ADDR_WRITE_DATA     = 2'h0;
   localparam logic [1:0]  ADDR_COMMAND        = 2'h1;
   localparam logic [1:0]  ADDR_STATUS         = 2'h2;
   localparam logic [1:0]  ADDR_READBACK       = 2'h3;
   // command codes written to the controller
   localparam logic [7:0]  CMD_PLAIN_WRITE     = 8'h01;
   localparam logic [7:0]  CMD_TIMED_WRITE     = 8'h02;
   localparam logic [7:0]  CMD_RESTART         = 8'h03;
   localparam logic [7:0]  CMD_READ            = 8'h04;
   typedef enum logic [1:0] {LEVEL_0, LEVEL_1, LEVEL_2} safety_level_type;
endpackage

// ===== wdg_if.sv
// interface joining the watchdog guard and its software controller
`timescale 1ns/10ps
interface wdg_if;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       restart;
   modport device (input wr_stb, input rd_stb, input wr_data, input restart, output rd_data);
   modport host   (output wr_stb, output rd_stb, output wr_data, output restart, input rd_data);
endinterface

// ===== watchdog_config_guard.sv
// watchdog enable and time-out change protection with timeout counter
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: level 0 takes time-out on any write
// RULE_02: level 0 disabling needs the timed sequence
// RULE_03: level 1 starts off, one write enables
// RULE_04: level 1 changes only inside open window
// RULE_05: software opens window writing change and on
// RULE_06: second write within four clocks is applied
// RULE_07: level 2 always runs, on reads one
// RULE_08: level 2 time-out only by sequence
// RULE_09: level 2 software opens with both bits
// RULE_10: level 2 ignores on bit in write
// RULE_11: software masks interrupts, restarts before disable
// RULE_12: change bit self-clears four clocks later
// RULE_13: level from two fuses, always-on gives 2
// RULE_14: select doubles period from 16K to 2048K
// RULE_15: expiry without restart issues chip reset
// RULE_16: levels 1,2 drop unwindowed time-out writes
module watchdog_config_guard #(
   parameter int unsigned BASE_LOG2 = wdg_pkg::BASE_PERIOD_LOG2
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_wdt_clk,
   input  wire logic       i_legacy_compat_fuse,
   input  wire logic       i_always_on_fuse,
   wdg_if.device           bus,
   output logic            o_chip_reset,
   output logic            o_watchdog_running,
   output logic [2:0]      o_timeout_select
);
   // whole state of the guard, registered in one place
   typedef struct packed {
      logic                               fuses_taken;
      wdg_pkg::safety_level_type          level;
      logic                               on;
      logic                               change;
      logic [1:0]                         win_cnt;
      logic [2:0]                         tsel;
      logic [2:0]                         osc_sync;
      logic                               osc_prev;
      logic [wdg_pkg::PERIOD_CNT_W-1:0]   period_cnt;
      logic                               chip_reset;
      logic [7:0]                         rd_data;
   } state_type;

   state_type state_reg;
   state_type state_next;

   // period length in oscillator cycles for a select code
   function automatic logic [wdg_pkg::PERIOD_CNT_W-1:0] period_of(input logic [2:0] sel);
      period_of = wdg_pkg::PERIOD_CNT_W'(1) << (BASE_LOG2 + 32'(sel)); // RULE_14
   endfunction

   // safety level from the fuse pair; the always-on fuse outranks compatibility
   function automatic wdg_pkg::safety_level_type level_of(input logic always_on, input logic compat);
      if (always_on) begin
         level_of = wdg_pkg::LEVEL_2; // RULE_13
      end else if (compat) begin
         level_of = wdg_pkg::LEVEL_0; // RULE_13
      end else begin
         level_of = wdg_pkg::LEVEL_1; // RULE_13
      end
   endfunction

   // a write completes a timed sequence only inside an open window and with change clear
   function automatic logic closes_window(input logic open, input logic chg);
      closes_window = open & ~chg;
   endfunction

   // byte seen by a read: reserved bits stay zero
   function automatic logic [7:0] ctrl_image(input logic chg, input logic on, input logic [2:0] tsel);
      ctrl_image = wdg_pkg::CTRL_RESET;
      ctrl_image[wdg_pkg::CHANGE_WINDOW_POS] = chg;
      ctrl_image[wdg_pkg::WATCHDOG_ON_POS]   = on;
      ctrl_image[wdg_pkg::TIMEOUT_SELECT_MSB -: wdg_pkg::TIMEOUT_SELECT_W] = tsel;
   endfunction

   logic       w_on;
   logic       w_chg;
   logic [2:0] w_tsel;
   logic       osc_tick;

   // fields of the incoming control write
   assign w_on   = bus.wr_data[wdg_pkg::WATCHDOG_ON_POS];
   assign w_chg  = bus.wr_data[wdg_pkg::CHANGE_WINDOW_POS];
   assign w_tsel = bus.wr_data[wdg_pkg::TIMEOUT_SELECT_MSB -: wdg_pkg::TIMEOUT_SELECT_W];
   // the oscillator is unrelated to the system clock, so only synchronised stages are read
   // rising oscillator edge counts once second and third stages agree
   assign osc_tick = state_reg.osc_sync[1] & state_reg.osc_sync[2] & ~state_reg.osc_prev;

   // next-state logic, in order of priority: fuse capture, window count, link write,
   // level 2 override, period counter, read image; a later step may overrule an
   // earlier one, which is how an opening write re-arms a window that is just closing
   // and how level 2 keeps the watchdog running whatever a write says
   always_comb begin
      state_next = state_reg;
      state_next.osc_sync = {state_reg.osc_sync[1:0], i_wdt_clk};
      if (state_reg.osc_sync[1] == state_reg.osc_sync[2]) begin
         state_next.osc_prev = state_reg.osc_sync[2];
      end
      state_next.chip_reset = 1'b0;
      // fuses are sampled once after reset release, not in the reset branch
      if (!state_reg.fuses_taken) begin
         state_next.fuses_taken = 1'b1;
         state_next.level       = level_of(i_always_on_fuse, i_legacy_compat_fuse); // RULE_13
         if (i_always_on_fuse) begin
            state_next.on = 1'b1; // RULE_07
         end else begin
            state_next.on = 1'b0; // RULE_03
         end
      end
      // window closes by itself after four clocks
      // counting from zero keeps the window counter two bits wide
      if (state_reg.change) begin
         if (state_reg.win_cnt == 2'(wdg_pkg::WINDOW_CLOCKS - 1)) begin
            state_next.change = 1'b0; // RULE_12
         end else begin
            state_next.win_cnt = state_reg.win_cnt + 2'd1;
         end
      end
      if (bus.wr_stb && state_reg.fuses_taken) begin
         if (w_chg && w_on) begin
            // opening write: restart the window count
            state_next.change  = 1'b1; // RULE_05 RULE_09
            state_next.win_cnt = 2'd0;
            state_next.on      = 1'b1;
            if (state_reg.level == wdg_pkg::LEVEL_0) begin
               state_next.tsel = w_tsel; // RULE_01
            end
         end else begin
            case (state_reg.level)
               wdg_pkg::LEVEL_0: begin
                  // any select goes through; stopping still needs the window
                  state_next.tsel = w_tsel; // RULE_01
                  if (w_on || state_reg.change) begin
                     state_next.on = w_on; // RULE_02
                  end
               end
               wdg_pkg::LEVEL_1: begin
                  // outside a window a plain write may start the watchdog but not stop it
                  if (closes_window(state_reg.change, w_chg)) begin
                     state_next.on   = w_on;   // RULE_04 RULE_06
                     state_next.tsel = w_tsel; // RULE_06
                  end else if (w_on) begin
                     state_next.on = 1'b1;     // RULE_03 RULE_16
                  end
               end
               wdg_pkg::LEVEL_2: begin
                  // the on bit carried by the closing write is ignored
                  if (closes_window(state_reg.change, w_chg)) begin
                     state_next.tsel = w_tsel; // RULE_08 RULE_10
                  end
               end
               default: state_next.on = state_reg.on;
            endcase
            if (state_reg.change) begin
               state_next.change = w_chg & state_next.change;
            end
         end
      end
      if (state_reg.level == wdg_pkg::LEVEL_2) begin
         state_next.on = 1'b1; // RULE_07 RULE_08
      end
      // counter cleared by restart, while off, and on its own expiry
      // a stopped watchdog holds zero, so starting it again always gives a full period
      if (bus.restart || !state_reg.on || !state_next.on) begin
         state_next.period_cnt = '0;
      end else if (osc_tick) begin
         if (state_reg.period_cnt >= period_of(state_reg.tsel) - 1'b1) begin
            state_next.chip_reset = 1'b1; // RULE_15
            state_next.period_cnt = '0;
         end else begin
            state_next.period_cnt = state_reg.period_cnt + 1'b1;
         end
      end
      // read data stands for the one cycle after the strobe and is zero otherwise,
      // so a stale byte can never be mistaken for a fresh one
      state_next.rd_data = wdg_pkg::CTRL_RESET;
      if (bus.rd_stb) begin
         state_next.rd_data = ctrl_image(state_next.change, state_next.on, state_next.tsel); // RULE_07
      end
   end

   // single state register
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // constants only: the fuses are read after release, never here
         state_reg <= '{fuses_taken: 1'b0,
                        level:       wdg_pkg::LEVEL_1,
                        on:          1'b0,
                        change:      1'b0,
                        win_cnt:     2'd0,
                        tsel:        wdg_pkg::TIMEOUT_RESET,
                        osc_sync:    3'h0,
                        osc_prev:    1'b0,
                        period_cnt:  '0,
                        chip_reset:  1'b0,
                        rd_data:     wdg_pkg::CTRL_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   // every output is a field of the state register
   assign bus.rd_data          = state_reg.rd_data;
   assign o_chip_reset         = state_reg.chip_reset;
   assign o_watchdog_running   = state_reg.on;
   assign o_timeout_select     = state_reg.tsel;
endmodule // watchdog_config_guard

// ===== watchdog_controller.sv
// software-facing controller that drives the watchdog control register
`timescale 1ns/10ps
module watchdog_controller (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   wdg_if.host             bus
);
   typedef enum logic [1:0] {IDLE, SECOND, READ_WAIT, READ_TAKE} ctl_state_type;
   typedef struct packed {
      ctl_state_type fsm;
      logic [7:0]    data;
      logic [7:0]    readback;
      logic          wr_stb;
      logic          rd_stb;
      logic          restart;
      logic [7:0]    wr_data;
      logic [7:0]    rdata;
   } ctl_type;

   ctl_type ctl_reg;
   ctl_type ctl_next;

   // commands launch link writes; timed write issues both steps back to back
   always_comb begin
      ctl_next = ctl_reg;
      ctl_next.wr_stb  = 1'b0;
      ctl_next.rd_stb  = 1'b0;
      ctl_next.restart = 1'b0;
      ctl_next.rdata   = 8'h00;
      case (ctl_reg.fsm)
         IDLE: begin
            if (i_wr && i_addr == wdg_pkg::ADDR_WRITE_DATA) begin
               ctl_next.data = i_wdata;
            end else if (i_wr && i_addr == wdg_pkg::ADDR_COMMAND) begin
               case (i_wdata)
                  wdg_pkg::CMD_PLAIN_WRITE: begin
                     ctl_next.wr_stb  = 1'b1;
                     ctl_next.wr_data = ctl_reg.data;
                  end
                  wdg_pkg::CMD_TIMED_WRITE: begin
                     // opening write sets both bits, whatever on reads now
                     ctl_next.wr_stb  = 1'b1; // RULE_05 RULE_09
                     ctl_next.wr_data = 8'(1 << wdg_pkg::CHANGE_WINDOW_POS) | 8'(1 << wdg_pkg::WATCHDOG_ON_POS);
                     ctl_next.restart = 1'b1; // RULE_11
                     ctl_next.fsm     = SECOND;
                  end
                  wdg_pkg::CMD_RESTART: ctl_next.restart = 1'b1;
                  wdg_pkg::CMD_READ: begin
                     ctl_next.rd_stb = 1'b1;
                     ctl_next.fsm    = READ_WAIT;
                  end
                  default: ctl_next.fsm = IDLE;
               endcase
            end
         end
         SECOND: begin
            // next clock, well inside the window; no other traffic can intervene
            ctl_next.wr_stb  = 1'b1; // RULE_06 RULE_10 RULE_11
            ctl_next.wr_data = ctl_reg.data & ~8'(1 << wdg_pkg::CHANGE_WINDOW_POS);
            ctl_next.fsm     = IDLE;
         end
         READ_WAIT: begin
            // the guard registers its answer on this edge; it stands only in the next cycle
            ctl_next.fsm = READ_TAKE;
         end
         READ_TAKE: begin
            ctl_next.readback = bus.rd_data;
            ctl_next.fsm      = IDLE;
         end
         default: ctl_next.fsm = IDLE;
      endcase
      if (i_rd) begin
         ctl_next.rdata = (i_addr == wdg_pkg::ADDR_READBACK) ? ctl_reg.readback :
                          (i_addr == wdg_pkg::ADDR_STATUS)   ? {6'h00, ctl_reg.fsm} : ctl_reg.data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_reg <= '{fsm: IDLE, data: 8'h00, readback: 8'h00, wr_stb: 1'b0, rd_stb: 1'b0,
                      restart: 1'b0, wr_data: 8'h00, rdata: 8'h00};
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign bus.wr_stb  = ctl_reg.wr_stb;
   assign bus.rd_stb  = ctl_reg.rd_stb;
   assign bus.restart = ctl_reg.restart;
   assign bus.wr_data = ctl_reg.wr_data;
   assign o_rdata     = ctl_reg.rdata;
endmodule // watchdog_controller

// ===== watchdog_config_guard_props.sv
// concurrent checks on the link between the watchdog guard and its controller
`timescale 1ns/10ps
module watchdog_config_guard_props (
   input wire logic       i_sys_clk,
   input wire logic       i_rst_n,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       restart,
   input wire logic       i_legacy_compat_fuse,
   input wire logic       i_always_on_fuse,
   input wire logic       o_chip_reset,
   input wire logic       o_watchdog_running,
   input wire logic [2:0] o_timeout_select
);
   logic [2:0] win_reg;
   logic [2:0] win_next;
   logic       applied;
   logic       restricted;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // shadow of the change window: reload on any write with the change bit, then count down
   always_comb begin
      win_next = (win_reg != 3'h0) ? win_reg - 3'h1 : 3'h0;
      if (wr_stb && wr_data[4]) win_next = 3'h4;
      applied = wr_stb && !wr_data[4] && (win_reg != 3'h0);
      restricted = !i_legacy_compat_fuse || i_always_on_fuse;
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) win_reg <= 3'h0;
      else win_reg <= win_next;
   end
   // output latency of one or two edges is allowed, so the select, stop and start checks look back at both
   chk_sel_windowed: assert property (restricted && $changed(o_timeout_select) |->
      $past(applied, 1) || $past(applied, 2)) else $error("select changed outside a window");
   chk_off_windowed: assert property ($fell(o_watchdog_running) && !o_chip_reset && !$past(o_chip_reset) |->
      $past(applied, 1) || $past(applied, 2)) else $error("watchdog stopped outside a window");
   chk_on_cause: assert property ($rose(o_watchdog_running) && !i_always_on_fuse |->
      $past(wr_stb && wr_data[3], 1) || $past(wr_stb && wr_data[3], 2)) else $error("watchdog started unasked");
   chk_level2_on: assert property (i_always_on_fuse && $past(o_watchdog_running) |-> o_watchdog_running)
      else $error("always-on watchdog stopped");
   chk_open_pair: assert property (wr_stb && restart |-> wr_data == 8'h18 ##1 wr_stb && !wr_data[4])
      else $error("timed pair malformed");
   chk_no_dual_stb: assert property (!(wr_stb && rd_stb)) else $error("read and write strobes together");
   chk_rd_slot: assert property (rd_data != 8'h00 |-> $past(rd_stb)) else $error("read data outside its slot");
   chk_reset_pulse: assert property (o_chip_reset |=> !o_chip_reset) else $error("chip reset longer than a cycle");
   chk_reset_cause: assert property (o_chip_reset |-> $past(o_watchdog_running))
      else $error("chip reset from a stopped watchdog");
   cov_window_apply: cover property (applied);
   cov_select_move: cover property (restricted && $changed(o_timeout_select));
   cov_expiry: cover property (o_chip_reset);
   cov_stop: cover property ($fell(o_watchdog_running));
endmodule // watchdog_config_guard_props

// ===== watchdog_config_guard_bench.sv
// self-checking bench: software port of the controller down to the guard outputs
`timescale 1ns/10ps
module watchdog_config_guard_bench;
   typedef struct {logic lf; logic af; logic [7:0] cmd; logic [7:0] dat; logic on; logic [2:0] sel;} row_type;
   logic       i_sys_clk;
   logic       i_rst_n;
   logic       wdt_clk;
   logic       lf;
   logic       af;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [7:0] v;
   logic       chip_reset;
   logic       running;
   logic [2:0] sel;
   int         error_cnt;
   int         comparisons;
   int         resets_seen;
   int         n;
   row_type    rows [9] = '{'{1, 0, 8'h01, 8'h05, 0, 3'h5}, '{1, 0, 8'h01, 8'h0d, 1, 3'h5},
      '{1, 0, 8'h02, 8'h02, 0, 3'h2}, '{0, 0, 8'h01, 8'h08, 1, 3'h0}, '{0, 0, 8'h01, 8'h0e, 1, 3'h0},
      '{0, 0, 8'h02, 8'h06, 0, 3'h6}, '{0, 1, 8'h01, 8'h03, 1, 3'h0}, '{0, 1, 8'h02, 8'h03, 1, 3'h3},
      '{1, 1, 8'h02, 8'h07, 1, 3'h7}};
   wdg_if link ();
   // base period shortened to 4 oscillator cycles so expiry fits in a short run
   watchdog_config_guard #(.BASE_LOG2(2)) watchdog_config_guard_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_wdt_clk(wdt_clk), .i_legacy_compat_fuse(lf), .i_always_on_fuse(af), .bus(link.device),
      .o_chip_reset(chip_reset), .o_watchdog_running(running), .o_timeout_select(sel));
   watchdog_controller watchdog_controller_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .bus(link.host));
   watchdog_config_guard_props watchdog_config_guard_props_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .wr_data(link.wr_data), .rd_data(link.rd_data),
      .restart(link.restart), .i_legacy_compat_fuse(lf), .i_always_on_fuse(af), .o_chip_reset(chip_reset),
      .o_watchdog_running(running), .o_timeout_select(sel));
   // system clock 100 MHz, oscillator free running and unrelated at 12.5 MHz
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      wdt_clk = 1'b0;
      forever #40 wdt_clk = ~wdt_clk;
   end
   always @(posedge i_sys_clk) if (chip_reset === 1'b1) resets_seen++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // reset is the only way to move to new fuse settings, since they are captured once
   task automatic rst(input logic f0, input logic f1);
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      lf <= f0;
      af <= f1;
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      resets_seen = 0;
   endtask
   task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_sys_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic sw_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic op(input logic [7:0] cmd, input logic [7:0] d);
      sw_write(wdg_pkg::ADDR_WRITE_DATA, d);
      sw_write(wdg_pkg::ADDR_COMMAND, cmd);
   endtask
   // link write N+4 after an opening write is the last one inside the window
   task automatic window_edge(input int d, input logic [7:0] exp);
      rst(1'h0, 1'h0);
      op(wdg_pkg::CMD_PLAIN_WRITE, 8'h18);
      repeat (d) @(posedge i_sys_clk);
      op(wdg_pkg::CMD_PLAIN_WRITE, 8'h05);
      repeat (4) @(posedge i_sys_clk);
      check({4'h0, running, sel}, exp);
   endtask
   initial begin
      i_rst_n = 1'b0;
      lf = 1'b0;
      af = 1'b0;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      foreach (rows[i]) begin
         rst(rows[i].lf, rows[i].af);
         check({7'h00, running}, {7'h00, rows[i].af});
         op(rows[i].cmd, rows[i].dat);
         repeat (4) @(posedge i_sys_clk);
         check({4'h0, running, sel}, {4'h0, rows[i].on, rows[i].sel});
      end
      $display("table rows done");
      window_edge(0, 8'h05);
      window_edge(1, 8'h08);
      $display("window boundary done");
      rst(1'h1, 1'h0);
      op(wdg_pkg::CMD_PLAIN_WRITE, 8'h08);
      op(wdg_pkg::CMD_PLAIN_WRITE, 8'h00);
      repeat (4) @(posedge i_sys_clk);
      check({7'h00, running}, 8'h01);
      repeat (20) op(wdg_pkg::CMD_RESTART, 8'h00);
      check(resets_seen[7:0], 8'h00);
      $display("restart and plain disable done");
      rst(1'h0, 1'h1);
      op(wdg_pkg::CMD_PLAIN_WRITE, 8'h00);
      op(wdg_pkg::CMD_READ, 8'h00);
      repeat (4) @(posedge i_sys_clk);
      sw_read(wdg_pkg::ADDR_READBACK, v);
      check({6'h00, v[4:3]}, 8'h01);
      check(v, 8'h08);
      $display("readback done");
      // expiry time doubles with each select step
      for (int s = 0; s < 2; s++) begin
         rst(1'h1, 1'h0);
         op(wdg_pkg::CMD_PLAIN_WRITE, 8'h08 | 8'(s));
         n = 0;
         while (resets_seen == 0 && n < 300) begin
            @(posedge i_sys_clk);
            n++;
         end
         check({7'h00, n >= (32 << s) - 12 && n <= (32 << s) + 18}, 8'h01);
      end
      $display("expiry done");
      report_and_stop();
   end
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
endmodule // watchdog_config_guard_bench
